//--- src/tw_defines.vh
// constants, register map and field layout of the timing and watchdog unit
// ---------------------------------------------------------------------------
// Function
// R1: slow clock divided by 1,2,4,8,16,32
// R2: timer is 16-bit down counter on tick
// R3: at zero reload from preset, keep counting
// R4: software programs preset 0001h..FFFFh only
// R5: zero gives one-tick pulse and sets flag
// R6: pulse raises interrupt if enabled; wakes
// R7: new preset used only at next reload
// R8: restart bit reloads on next tick, self-clears
// R9: software waits restart before power-save/idle
// R10: watchdog is 8-bit down counter
// R11: disabled after reset; first write starts it
// R12: once started only reset stops watchdog
// R13: watchdog clock is pulse or tick
// R14: count write reloads counter when matching off
// R15: 5Ch match write reloads programmed count
// R16: error on late, often, or wrong key
// R17: watchdog error resets whole device
// R18: locked register ignores writes, reads junk
// R19: locks hold until device reset
// R20: counters run in save/idle; only match reg
// R21: halt freezes block, resumes same state; match writes in halt still reload watchdog or raise key error
// R22: software waits 5 slow cycles before save
// R23: select set uses tick, clear uses pulse
// R24: preset resets to FFFFh
// R25: counter zero before service means too late
// R26: two services in one period too often
// R27: each lock bit acts on its own
// ---------------------------------------------------------------------------
`ifndef TW_DEFINES_VH
`define TW_DEFINES_VH

// ---------------------------------------------------------------------------
// register indices, byte address is four times the index
// ---------------------------------------------------------------------------
`define TW_IDX_CFG      10'h020
`define TW_IDX_PRESCALE 10'h022
`define TW_IDX_PRESET   10'h024
`define TW_IDX_CSR      10'h026
`define TW_IDX_WDCOUNT  10'h028
`define TW_IDX_MATCH    10'h02A
`define TW_IDX_STATUS   10'h02C

// ---------------------------------------------------------------------------
// timing_config_reg fields
// ---------------------------------------------------------------------------
`define TW_CFG_LOCK_CFG   0
`define TW_CFG_LOCK_PRE   1
`define TW_CFG_LOCK_TMR   2
`define TW_CFG_LOCK_WDC   3
`define TW_CFG_WD_CLKSEL  4
`define TW_CFG_MATCH_EN   5
`define TW_CFG_RESET      6'h00

// ---------------------------------------------------------------------------
// timer_control_status_reg fields
// ---------------------------------------------------------------------------
`define TW_CSR_RESTART    0
`define TW_CSR_DONE       1
`define TW_CSR_INTE       2

// ---------------------------------------------------------------------------
// reset values, service key, power modes, access answers
// ---------------------------------------------------------------------------
`define TW_PRESET_RESET   16'hFFFF
`define TW_MDIV_RESET     3'h0
`define TW_WDCOUNT_RESET  8'h00
`define TW_SERVICE_KEY    8'h5C
`define TW_MODE_ACTIVE    2'h0
`define TW_MODE_SAVE      2'h1
`define TW_MODE_IDLE      2'h2
`define TW_MODE_HALT      2'h3
`define TW_ACC_NONE       2'h0
`define TW_ACC_BLOCKED    2'h1
`define TW_ACC_OK         2'h2
`define TW_MDIV_MAX       3'h5

`endif

//--- src/tw_prescale.v
// prescaler that turns slow clock edges into the prescaled tick
`timescale 1ns/1ps
`include "tw_defines.vh"

module tw_prescale (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       slow_edge,
    input  wire       run,
    input  wire [2:0] mdiv,
    output reg        tick
);

    reg [4:0] div_cnt;

    // reserved codes fall back to the largest divisor
    function [4:0] div_last;
        input [2:0] code;
        begin
            if (code > `TW_MDIV_MAX) begin
                div_last = 5'h1F;
            end else begin
                div_last = (5'h01 << code) - 5'h01;
            end
        end
    endfunction

    // ---------------------------------------------------------------------
    // divider, frozen while run is low
    // ---------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 5'h00;
            tick    <= 1'b0;
        end else if (run && slow_edge) begin
            if (div_cnt >= div_last(mdiv)) begin // [R1]
                div_cnt <= 5'h00;
                tick    <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 5'h01;
                tick    <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule // tw_prescale

//--- src/tw_timer_wdt.v
// timing and watchdog unit: periodic timer, watchdog, locks, apb slave
`timescale 1ns/1ps
`include "tw_defines.vh"

module tw_timer_wdt (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        slow_clock,
    input  wire [1:0]  power_mode,
    output reg         timer_output_pulse,
    output reg         timer_interrupt_line,
    output reg         watchdog_reset_req
);

    // ---------------------------------------------------------------------
    // state
    // ---------------------------------------------------------------------
    reg        slow_s1;
    reg        slow_s2;
    reg        slow_s3;
    reg [5:0]  cfg;
    reg [2:0]  mdiv;
    reg [15:0] preset;
    reg [15:0] tmr_cnt;
    reg        restart;
    reg        done_flag;
    reg        tmr_inte;
    reg [7:0]  wd_count_val;
    reg [7:0]  wd_cnt;
    reg        wd_run;
    reg        wd_served;
    reg [31:0] next_prdata;
    reg        next_pslverr;

    wire       tick;
    wire       slow_edge;
    wire       run;
    wire       active;
    wire [9:0] idx;
    wire [1:0] acc;
    wire       wr;
    wire       wr_ok;
    wire       zero_evt;
    wire       wd_evt;
    wire       match_en;
    wire       cnt_wr;
    wire       key_wr;
    wire       svc_cnt;
    wire       svc_key;
    wire       bad_key;
    wire       service;
    wire       start_only;
    wire       wd_load;
    wire [7:0] wd_load_val;
    wire       too_often;
    wire       too_late;

    // ---------------------------------------------------------------------
    // access decision per register
    // ---------------------------------------------------------------------
    // only the match register answers outside active mode; a lock blocks
    // its own register and nothing else
    function [1:0] reg_access;
        input [9:0] r;
        input       act;
        input [5:0] c;
        begin
            case (r)
                `TW_IDX_MATCH: begin
                    reg_access = `TW_ACC_OK; // [R20]
                end
                `TW_IDX_CFG: begin
                    reg_access = (act && !c[`TW_CFG_LOCK_CFG]) ?
                                 `TW_ACC_OK : `TW_ACC_BLOCKED; // [R18] [R27]
                end
                `TW_IDX_PRESCALE: begin
                    reg_access = (act && !c[`TW_CFG_LOCK_PRE]) ?
                                 `TW_ACC_OK : `TW_ACC_BLOCKED; // [R18] [R27]
                end
                `TW_IDX_PRESET, `TW_IDX_CSR: begin
                    reg_access = (act && !c[`TW_CFG_LOCK_TMR]) ?
                                 `TW_ACC_OK : `TW_ACC_BLOCKED; // [R18] [R27]
                end
                `TW_IDX_WDCOUNT: begin
                    reg_access = (act && !c[`TW_CFG_LOCK_WDC]) ?
                                 `TW_ACC_OK : `TW_ACC_BLOCKED; // [R18] [R27]
                end
                `TW_IDX_STATUS: begin
                    reg_access = act ? `TW_ACC_OK : `TW_ACC_BLOCKED; // [R20]
                end
                default: begin
                    reg_access = `TW_ACC_NONE;
                end
            endcase
        end
    endfunction

    // ---------------------------------------------------------------------
    // slow clock synchroniser and edge
    // ---------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_s3 <= 1'b0;
        end else begin
            slow_s1 <= slow_clock;
            slow_s2 <= slow_s1;
            slow_s3 <= slow_s2;
        end
    end

    assign slow_edge = slow_s2 && !slow_s3;
    assign run       = (power_mode != `TW_MODE_HALT); // [R21]
    assign active    = (power_mode == `TW_MODE_ACTIVE);

    tw_prescale u_prescale (
        .pclk      (pclk),
        .presetn   (presetn),
        .slow_edge (slow_edge),
        .run       (run),
        .mdiv      (mdiv),
        .tick      (tick)
    );

    // ---------------------------------------------------------------------
    // apb slave, zero wait states
    // ---------------------------------------------------------------------
    assign idx   = paddr[11:2];
    assign acc   = reg_access(idx, active, cfg);
    assign wr    = psel && penable && pready && pwrite;
    assign wr_ok = wr && (acc == `TW_ACC_OK);

    // locked or mode-blocked reads return zero as their unpredictable value
    always @* begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = (acc == `TW_ACC_NONE);
        if (acc == `TW_ACC_OK) begin
            case (idx)
                `TW_IDX_CFG: begin
                    next_prdata = {26'h0, cfg};
                end
                `TW_IDX_PRESCALE: begin
                    next_prdata = {29'h0, mdiv};
                end
                `TW_IDX_PRESET: begin
                    next_prdata = {16'h0, preset};
                end
                `TW_IDX_CSR: begin
                    next_prdata = {29'h0, tmr_inte, done_flag, restart};
                end
                `TW_IDX_WDCOUNT: begin
                    next_prdata = {24'h0, wd_count_val};
                end
                `TW_IDX_STATUS: begin
                    next_prdata = {15'h0, wd_run, tmr_cnt};
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                pslverr <= next_pslverr;
                prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------------
    // configuration, prescaler and preset registers
    // ---------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg          <= `TW_CFG_RESET;
            mdiv         <= `TW_MDIV_RESET;
            preset       <= `TW_PRESET_RESET; // [R24]
            tmr_inte     <= 1'b0;
            wd_count_val <= `TW_WDCOUNT_RESET;
        end else if (wr_ok) begin
            case (idx)
                `TW_IDX_CFG: begin
                    // lock bits only ever set, never clear
                    cfg[3:0] <= cfg[3:0] | pwdata[3:0]; // [R19]
                    cfg[`TW_CFG_WD_CLKSEL] <= pwdata[`TW_CFG_WD_CLKSEL];
                    cfg[`TW_CFG_MATCH_EN]  <= pwdata[`TW_CFG_MATCH_EN];
                end
                `TW_IDX_PRESCALE: begin
                    mdiv <= pwdata[2:0]; // [R1]
                end
                `TW_IDX_PRESET: begin
                    // only the reload reads this, so the countdown in
                    // progress is untouched
                    preset <= pwdata[15:0]; // [R7]
                end
                `TW_IDX_CSR: begin
                    tmr_inte <= pwdata[`TW_CSR_INTE];
                end
                `TW_IDX_WDCOUNT: begin
                    wd_count_val <= pwdata[7:0];
                end
                default: begin
                    cfg <= cfg;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------------
    // periodic timer
    // ---------------------------------------------------------------------
    assign zero_evt = tick && !restart && (tmr_cnt == 16'h0000); // [R3]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_cnt            <= `TW_PRESET_RESET;
            timer_output_pulse <= 1'b0;
        end else if (tick) begin
            if (restart) begin
                tmr_cnt            <= preset; // [R8]
                timer_output_pulse <= 1'b0;
            end else if (tmr_cnt == 16'h0000) begin
                tmr_cnt            <= preset; // [R3]
                timer_output_pulse <= 1'b1; // [R5] [R6]
            end else begin
                tmr_cnt            <= tmr_cnt - 16'h0001; // [R2]
                timer_output_pulse <= 1'b0;
            end
        end
    end

    // restart request: a write in the same cycle as the tick stays pending
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart <= 1'b0;
        end else if (wr_ok && idx == `TW_IDX_CSR &&
                     pwdata[`TW_CSR_RESTART]) begin
            restart <= 1'b1;
        end else if (tick) begin
            restart <= 1'b0; // [R8]
        end
    end

    // completion flag, write one to clear; a new zero wins over the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
        end else if (zero_evt) begin
            done_flag <= 1'b1; // [R5]
        end else if (wr_ok && idx == `TW_IDX_CSR &&
                     pwdata[`TW_CSR_DONE]) begin
            done_flag <= 1'b0;
        end
    end

    // interrupt follows the pulse for the same tick cycle when enabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_interrupt_line <= 1'b0;
        end else if (tick) begin
            timer_interrupt_line <= zero_evt && tmr_inte; // [R6]
        end
    end

    // ---------------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------------
    assign match_en = cfg[`TW_CFG_MATCH_EN];
    assign wd_evt   = cfg[`TW_CFG_WD_CLKSEL] ? tick : zero_evt; // [R13] [R23]
    assign cnt_wr   = wr_ok && (idx == `TW_IDX_WDCOUNT);
    assign key_wr   = wr_ok && (idx == `TW_IDX_MATCH);
    assign svc_cnt  = cnt_wr && !match_en; // [R14]
    assign svc_key  = key_wr && match_en &&
                      (pwdata[7:0] == `TW_SERVICE_KEY); // [R15]
    assign bad_key  = key_wr && match_en &&
                      (pwdata[7:0] != `TW_SERVICE_KEY); // [R16]
    assign service  = svc_cnt || svc_key;

    // a count write with matching on, or a match write with matching off, still starts an idle watchdog
    assign start_only = !wd_run && ((cnt_wr && match_en) ||
                                    (key_wr && !match_en)); // [R11]
    assign wd_load    = service || start_only;
    assign wd_load_val = (cnt_wr) ? pwdata[7:0] : wd_count_val;

    assign too_often = service && wd_run && wd_served; // [R26]
    assign too_late  = wd_run && wd_evt && !service &&
                       (wd_cnt == 8'h00); // [R25]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_run <= 1'b0; // [R11]
            wd_cnt <= `TW_WDCOUNT_RESET;
        end else if (wd_load) begin
            wd_run <= 1'b1; // [R12]
            wd_cnt <= wd_load_val; // [R14] [R15]
        end else if (wd_run && wd_evt && wd_cnt != 8'h00) begin
            wd_cnt <= wd_cnt - 8'h01; // [R10]
        end
    end

    // remembers a service since the last watchdog clock edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_served <= 1'b0;
        end else if (service) begin
            wd_served <= 1'b1;
        end else if (wd_evt) begin
            wd_served <= 1'b0;
        end
    end

    // held until the device reset that it causes clears it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset_req <= 1'b0;
        end else if (too_late || too_often || bad_key) begin
            watchdog_reset_req <= 1'b1; // [R16] [R17]
        end
    end

endmodule // tw_timer_wdt

//--- sim/tw_timer_wdt_asserts.sv
// concurrent checks on the ports of the timing and watchdog unit
`timescale 1ns/1ps
`include "tw_defines.vh"

module tw_timer_wdt_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        slow_clock,
    input wire [1:0]  power_mode,
    input wire        timer_output_pulse,
    input wire        timer_interrupt_line,
    input wire        watchdog_reset_req
);
    // ---------------------------------------------------------------
    // shadow of the match-service enable, to judge a wrong key
    // ---------------------------------------------------------------
    reg        mt_en;
    reg        lk_cfg;
    wire       acc = psel && penable && pready;
    wire [9:0] idx = paddr[11:2];
    wire       mapped = idx >= `TW_IDX_CFG && idx <= `TW_IDX_STATUS
                        && !idx[0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mt_en <= 1'b0;
            lk_cfg <= 1'b0;
        end else if (acc && pwrite && idx == `TW_IDX_CFG && !lk_cfg
                     && power_mode == `TW_MODE_ACTIVE) begin
            mt_en <= pwdata[`TW_CFG_MATCH_EN];
            lk_cfg <= pwdata[`TW_CFG_LOCK_CFG];
        end
    end

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready");

    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("long ready");

    property p_slverr_map;
        acc |-> pslverr == !mapped && (pwrite || mapped || prdata == 32'h0);
    endproperty
    a_slverr_map: assert property (p_slverr_map) else $error("bad slverr");

    property p_irq_pulse;
        timer_interrupt_line |-> timer_output_pulse;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("lone irq");

    property p_pulse_hold;
        $rose(timer_output_pulse) |=>
            timer_output_pulse ##1 timer_output_pulse;
    endproperty
    a_pulse_hold: assert property (p_pulse_hold)
        else $error("short pulse");

    property p_wd_sticky;
        watchdog_reset_req |=> watchdog_reset_req;
    endproperty
    a_wd_sticky: assert property (p_wd_sticky)
        else $error("error lost");

    property p_halt_freeze;
        (power_mode == `TW_MODE_HALT) [*4] |->
            $stable(timer_output_pulse) && $stable(timer_interrupt_line);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze)
        else $error("halt moved");

    property p_wrong_key;
        acc && pwrite && idx == `TW_IDX_MATCH && mt_en
        && power_mode != `TW_MODE_HALT && pwdata[7:0] != `TW_SERVICE_KEY
        |-> ##[1:2] watchdog_reset_req;
    endproperty
    a_wrong_key: assert property (p_wrong_key)
        else $error("key no error");

    property p_blocked_read;
        acc && !pwrite && idx != `TW_IDX_MATCH
        && power_mode != `TW_MODE_ACTIVE
        && $past(power_mode) != `TW_MODE_ACTIVE |-> prdata == 32'h0;
    endproperty
    a_blocked_read: assert property (p_blocked_read)
        else $error("read open");
endmodule // tw_timer_wdt_asserts

//--- sim/testbench.sv
// self-checking bench for the timing and watchdog unit
`timescale 1ns/1ps
`include "tw_defines.vh"

module testbench;
    localparam integer LIMIT = 40000;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg         slow_clock = 1'b0;
    reg  [1:0]  power_mode = 2'h0;
    reg  [2:0]  slow_div = 3'h0;
    reg         slow_q = 1'b0;
    reg  [32:0] expq[$];
    reg  [32:0] exp_v;
    reg  [31:0] v;
    integer     nslow = 0;
    integer     cyc = 0;
    integer     failures = 0;
    integer     check_count = 0;
    integer     seed = 92;
    integer     d, k, n, mark;
    wire [31:0] prdata;
    wire        pready, pslverr, timer_output_pulse;
    wire        timer_interrupt_line, watchdog_reset_req;

    tw_timer_wdt tw_timer_wdt_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_clock(slow_clock),
        .power_mode(power_mode), .timer_output_pulse(timer_output_pulse),
        .timer_interrupt_line(timer_interrupt_line),
        .watchdog_reset_req(watchdog_reset_req)
    );

    always #5 pclk = ~pclk;

    // slow clock at pclk/8; rises are counted for periods
    always @(posedge pclk) begin
        slow_div <= slow_div + 3'h1;
        slow_clock <= slow_div[2];
        slow_q <= slow_clock;
        if (slow_clock && !slow_q) nslow <= nslow + 1;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures = failures + 1;
            results;
        end
    end

    // read monitor: oldest note against the access answer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            exp_v = expq.pop_front();
            check_count = check_count + 1;
            if ({pslverr, prdata} !== exp_v) begin
                failures = failures + 1;
                $display("mismatch read %h expected %h seen %h", paddr,
                         exp_v, {pslverr, prdata});
            end
        end
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task results;
        begin
            $display("checks %0d mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // request held until pready is sampled high, released after it
    task apb(input w, input [11:0] a, input [31:0] dt, input [32:0] e);
        begin
            if (!w) expq.push_back(e);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= dt;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task wr(input [9:0] i, input [31:0] dt);
        apb(1'b1, {i, 2'h0}, dt, 33'h0);
    endtask

    task rd(input [9:0] i, input [31:0] e);
        apb(1'b0, {i, 2'h0}, 32'h0, {1'b0, e});
    endtask

    task wait_rise;
        begin
            while (timer_output_pulse !== 1'b0) @(posedge pclk);
            while (timer_output_pulse !== 1'b1) @(posedge pclk);
        end
    endtask

    task span(input integer e);
        begin
            wait_rise;
            chk("slow edges per period", e, nslow - mark);
            mark = nslow;
        end
    endtask

    task do_reset;
        begin
            presetn <= 1'b0;
            repeat (12) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
        end
    endtask

    task prep;
        begin
            do_reset;
            wr(`TW_IDX_PRESET, 32'h2);
            wr(`TW_IDX_CSR, 32'h1);
        end
    endtask

    task wdrun(input [31:0] cfg, input [31:0] cnt, input integer lo,
               input integer hi);
        begin
            prep;
            wr(`TW_IDX_CFG, cfg);
            repeat (100) @(posedge pclk);
            chk("watchdog idle", 1'b0, watchdog_reset_req);
            wr(`TW_IDX_WDCOUNT, cnt);
            n = 0;
            while (watchdog_reset_req !== 1'b1 && n < 400) begin
                @(posedge pclk);
                n = n + 1;
            end
            chk("watchdog expiry", 1'b1, n >= lo && n <= hi);
        end
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        do_reset;
        rd(`TW_IDX_PRESET, 32'hFFFF);
        rd(`TW_IDX_CFG, 32'h0);
        apb(1'b0, 12'h084, 32'h0, 33'h100000000);
        power_mode <= `TW_MODE_SAVE;
        wr(`TW_IDX_PRESET, 32'h1234);
        rd(`TW_IDX_PRESET, 32'h0);
        power_mode <= `TW_MODE_ACTIVE;
        rd(`TW_IDX_PRESET, 32'hFFFF);
        $display("test reset and modes done");
        v = $random(seed) | 32'h1;
        wr(`TW_IDX_PRESET, {16'h0, v[15:0]});
        rd(`TW_IDX_PRESET, {16'h0, v[15:0]});
        d = v[17:16] + 1;
        wr(`TW_IDX_PRESET, d);
        wr(`TW_IDX_CSR, 32'h1);
        for (k = 5; k >= 0; k = k - 1) begin
            wr(`TW_IDX_PRESCALE, k);
            wait_rise;
            wait_rise;
            mark = nslow;
            span((d + 1) * (1 << k));
        end
        wr(`TW_IDX_PRESET, d + 3);
        span(d + 1);
        span(d + 4);
        chk("irq masked", 1'b0, timer_interrupt_line);
        wr(`TW_IDX_CSR, 32'h4);
        wait_rise;
        chk("irq enabled", 1'b1, timer_interrupt_line);
        rd(`TW_IDX_CSR, 32'h6);
        power_mode <= `TW_MODE_HALT;
        repeat (200) @(posedge pclk);
        power_mode <= `TW_MODE_ACTIVE;
        $display("test timer done");
        wr(`TW_IDX_CFG, 32'h2);
        wr(`TW_IDX_PRESCALE, 32'h3);
        rd(`TW_IDX_PRESCALE, 32'h0);
        wr(`TW_IDX_PRESET, 32'h77);
        rd(`TW_IDX_PRESET, 32'h77);
        wr(`TW_IDX_CFG, 32'h0);
        rd(`TW_IDX_CFG, 32'h2);
        wr(`TW_IDX_CFG, 32'h1);
        rd(`TW_IDX_CFG, 32'h0);
        $display("test locks done");
        wdrun(32'h10, 32'h4, 24, 56);
        rd(`TW_IDX_CFG, 32'h10);
        wdrun(32'h00, 32'h2, 40, 90);
        prep;
        wr(`TW_IDX_WDCOUNT, 32'h4);
        wait_rise;
        wr(`TW_IDX_WDCOUNT, 32'h4);
        wait_rise;
        chk("count service", 1'b0, watchdog_reset_req);
        wr(`TW_IDX_WDCOUNT, 32'h4);
        wr(`TW_IDX_WDCOUNT, 32'h4);
        repeat (4) @(posedge pclk);
        chk("service too often", 1'b1, watchdog_reset_req);
        prep;
        wr(`TW_IDX_CFG, 32'h20);
        wr(`TW_IDX_WDCOUNT, 32'h3);
        for (k = 0; k < 3; k = k + 1) begin
            wait_rise;
            wr(`TW_IDX_MATCH, 32'h5C);
        end
        chk("key service", 1'b0, watchdog_reset_req);
        wr(`TW_IDX_MATCH, 32'h33);
        repeat (4) @(posedge pclk);
        chk("wrong key", 1'b1, watchdog_reset_req);
        $display("test watchdog done");
        results;
    end
endmodule // testbench

bind tw_timer_wdt tw_timer_wdt_asserts tw_timer_wdt_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_clock(slow_clock),
    .power_mode(power_mode), .timer_output_pulse(timer_output_pulse),
    .timer_interrupt_line(timer_interrupt_line),
    .watchdog_reset_req(watchdog_reset_req)
);
